// [dcs_top.sv]
// Debug comparator sequencer with AHB-Lite register slave
//
// Chosen here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
module dcs_top (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        pc_exec_valid,
    input  wire logic [23:0] pc_exec_addr,
    input  wire logic        data_valid,
    input  wire logic        data_write,
    input  wire logic [23:0] data_addr,
    input  wire logic [31:0] data_bus,
    input  wire logic        ext_event,
    output logic             breakpoint,
    output logic [3:0]       match_out,
    output logic [1:0]       seq_state,
    output logic             irq
);
    // ************************************************************
    // Bus slave
    // ************************************************************
    logic                wr_pend_reg;
    logic                rd_pend_reg;
    logic [7:0]          addr_q_reg;
    logic [31:0]         hrdata_reg;
    logic [7:0]          cmp_ctl_reg [3];
    logic [23:0]         cmp_addr_reg [3];
    logic [31:0]         data_val_reg;
    logic [31:0]         data_mask_reg;
    logic                bken_reg;
    logic [1:0]          ftgt_reg;
    logic [1:0]          range_reg;
    logic [3:0]          status_reg;
    logic [3:0]          mask_reg;
    logic [2:0]          fired_reg;
    logic                bkpt_reg;
    logic [3:0]          match_reg;
    dcs_pkg::dcs_state_t state_reg;
    dcs_pkg::dcs_state_t state_next;

    // Only the low address byte is decoded, so the map repeats every 256 bytes
    wire        accept    = hsel && htrans[1] && hready;
    wire        wr_ctrl   = wr_pend_reg && (addr_q_reg == dcs_pkg::CTRL1_OFF);
    wire        wr_range  = wr_pend_reg && (addr_q_reg == dcs_pkg::RANGE_OFF);
    wire        wr_mask   = wr_pend_reg && (addr_q_reg == dcs_pkg::MASK_OFF);
    wire        rd_status = rd_pend_reg && (addr_q_reg == dcs_pkg::STATUS_OFF);
    wire [3:0]  cmp_sel   = addr_q_reg[7:4] - dcs_pkg::CMP_BASE;
    wire        cmp_area  = (addr_q_reg[7:4] >= dcs_pkg::CMP_BASE) && (cmp_sel < 4'h3);
    wire [3:0]  cmp_sub   = addr_q_reg[3:0];
    wire [1:0]  ci        = cmp_sel[1:0];
    wire        wr_dval   = wr_pend_reg && cmp_area && (ci == 2'h0) && (cmp_sub == dcs_pkg::CMP_DATA);
    wire        wr_dmask  = wr_pend_reg && cmp_area && (ci == 2'h0) && (cmp_sub == dcs_pkg::CMP_DMASK);
    wire        arm_wr    = wr_ctrl && hwdata[dcs_pkg::ARM_BIT];
    wire        disarm_wr = wr_ctrl && !hwdata[dcs_pkg::ARM_BIT];
    wire        force_wr  = wr_ctrl && hwdata[dcs_pkg::FORCE_BIT];

    // Reads take one wait state so a write just ahead is already stored
    assign hreadyout = !rd_pend_reg;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;

    wire [31:0] cmp_rd =
        (cmp_sub == dcs_pkg::CMP_CTL)               ? {24'h000000, cmp_ctl_reg[ci]} :
        (cmp_sub == dcs_pkg::CMP_ADDR)              ? {8'h00, cmp_addr_reg[ci]} :
        ((cmp_sub == dcs_pkg::CMP_DATA) && ci == 2'h0)  ? data_val_reg :
        ((cmp_sub == dcs_pkg::CMP_DMASK) && ci == 2'h0) ? data_mask_reg : 32'h00000000;
    wire [31:0] rd_data =
        (addr_q_reg == dcs_pkg::CTRL1_OFF)  ? {26'h0, ftgt_reg, 1'b0, bken_reg, 1'b0,
                                               state_reg != dcs_pkg::DCS_IDLE} :
        (addr_q_reg == dcs_pkg::RANGE_OFF)  ? {30'h0, range_reg} :
        (addr_q_reg == dcs_pkg::STATUS_OFF) ? {28'h0000000, status_reg} :
        (addr_q_reg == dcs_pkg::MASK_OFF)   ? {28'h0000000, mask_reg} :
        (addr_q_reg == dcs_pkg::SEQ_OFF)    ? {25'h0, fired_reg, 2'h0, state_reg} :
        cmp_area                            ? cmp_rd : 32'h00000000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_q_reg  <= 8'h00;
            hrdata_reg  <= 32'h00000000;
        end else begin
            wr_pend_reg <= accept && hwrite;
            rd_pend_reg <= accept && !hwrite;
            if (accept) addr_q_reg <= haddr[7:0];
            if (rd_pend_reg) hrdata_reg <= rd_data;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bken_reg      <= 1'b0;
            ftgt_reg      <= dcs_pkg::TGT_FINAL;
            range_reg     <= dcs_pkg::RANGE_OFF_MODE;
            mask_reg      <= 4'h0;
            data_val_reg  <= dcs_pkg::DATA_RST;
            data_mask_reg <= dcs_pkg::DMASK_RST;
        end else begin
            if (wr_ctrl) begin
                bken_reg <= hwdata[dcs_pkg::BKEN_BIT];
                ftgt_reg <= hwdata[dcs_pkg::FTGT_LSB +: 2];
            end
            if (wr_range) range_reg <= hwdata[1:0];
            if (wr_mask) mask_reg <= hwdata[3:0];
            if (wr_dval) data_val_reg <= hwdata;
            if (wr_dmask) data_mask_reg <= hwdata;
        end
    end

    // ************************************************************
    // Comparators
    // ************************************************************
    // Range modes borrow B's address as the upper bound, so B itself stays quiet
    logic [2:0] hit;
    wire        range_on = (range_reg != dcs_pkg::RANGE_OFF_MODE);

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_cmp
            wire [7:0]  ctl    = cmp_ctl_reg[g];
            wire        opc    = ctl[dcs_pkg::OPC_BIT];
            wire [23:0] a_cmp  = opc ? pc_exec_addr : data_addr;
            wire        eq     = (a_cmp == cmp_addr_reg[g]);
            wire        inr    = (a_cmp >= cmp_addr_reg[0]) && (a_cmp <= cmp_addr_reg[1]);
            wire        rng_ok = (range_reg == dcs_pkg::RANGE_IN) ? inr : !inr;
            wire        a_ok   = (g == 0 && range_on && !opc) ? rng_ok : eq;
            wire        rw_ok  = !ctl[dcs_pkg::ATCE_BIT] ||
                                 (ctl[dcs_pkg::RDSEL_BIT] == !data_write);
            wire        d_ok   = (g != 0) || !ctl[dcs_pkg::DCE_BIT] ||
                                 (((data_bus ^ data_val_reg) & data_mask_reg) == 32'h00000000);
            wire        b_off  = (g == 1) && range_on;
            // Opcode side ignores data, mask and direction qualifiers
            wire        h_opc  = pc_exec_valid && eq;
            wire        h_dat  = data_valid && a_ok && rw_ok && d_ok;
            assign hit[g] = ctl[dcs_pkg::EN_BIT] && !b_off && (opc ? h_opc : h_dat);

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    cmp_ctl_reg[g]  <= dcs_pkg::CTL_RST;
                    cmp_addr_reg[g] <= dcs_pkg::ADDR_RST;
                end else if (wr_pend_reg && cmp_area && ci == 2'(g)) begin
                    if (cmp_sub == dcs_pkg::CMP_CTL) cmp_ctl_reg[g] <= hwdata[7:0];
                    if (cmp_sub == dcs_pkg::CMP_ADDR) cmp_addr_reg[g] <= hwdata[23:0];
                end
            end
        end
    endgenerate

    // ************************************************************
    // Sequencer
    // ************************************************************
    wire       armed    = (state_reg != dcs_pkg::DCS_IDLE);
    wire       force_go = armed && (force_wr || ext_event);
    wire       match_go = armed && (hit != 3'h0);
    wire       ev_go    = force_go || match_go;
    wire [1:0] ev_tgt   = force_go ? ftgt_reg :
                          hit[0]   ? cmp_ctl_reg[0][dcs_pkg::TGT_LSB +: 2] :
                          hit[1]   ? cmp_ctl_reg[1][dcs_pkg::TGT_LSB +: 2] :
                                     cmp_ctl_reg[2][dcs_pkg::TGT_LSB +: 2];
    wire       final_go = ev_go && (ev_tgt == dcs_pkg::TGT_FINAL);
    wire       bk_ev    = final_go && bken_reg;
    wire [3:0] st_set   = {hit, bk_ev};

    always_comb begin
        state_next = state_reg;
        if (!armed) begin
            if (arm_wr) state_next = dcs_pkg::DCS_S1;
        end else if (disarm_wr) begin
            state_next = dcs_pkg::DCS_IDLE;
        end else if (final_go) begin
            state_next = dcs_pkg::DCS_IDLE;
        end else if (ev_go) begin
            state_next = dcs_pkg::dcs_state_t'(ev_tgt);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg  <= dcs_pkg::DCS_IDLE;
            bkpt_reg   <= 1'b0;
            match_reg  <= 4'h0;
            fired_reg  <= 3'h0;
            status_reg <= 4'h0;
        end else begin
            state_reg  <= state_next;
            bkpt_reg   <= bk_ev;
            match_reg  <= {hit[2], 1'b0, hit[1], hit[0]};
            fired_reg  <= (arm_wr ? 3'h0 : fired_reg) | hit;
            // A new event wins over the read that clears it
            status_reg <= (rd_status ? 4'h0 : status_reg) | st_set;
        end
    end

    assign breakpoint = bkpt_reg;
    assign match_out  = match_reg;
    assign seq_state  = state_reg;
    assign irq        = |(status_reg & mask_reg);

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_idle_ignore;
        (state_reg == dcs_pkg::DCS_IDLE) && !arm_wr |=> state_reg == dcs_pkg::DCS_IDLE;
    endproperty
    a_idle_ignore: assert property (p_idle_ignore) else $error("idle sequencer moved");

    property p_final_idle;
        armed && !disarm_wr && force_go && ftgt_reg == dcs_pkg::TGT_FINAL && bken_reg
            |=> breakpoint && state_reg == dcs_pkg::DCS_IDLE ##1 !breakpoint;
    endproperty
    a_final_idle: assert property (p_final_idle) else $error("final state misbehaved");

    property p_map;
        !range_on && data_valid && cmp_ctl_reg[1] == 8'h01 && data_addr == cmp_addr_reg[1]
            |=> match_out[1] && !match_out[2];
    endproperty
    a_map: assert property (p_map) else $error("comparator B not on match 1");

    property p_opcode;
        pc_exec_valid && cmp_ctl_reg[2][1:0] == 2'h3 && pc_exec_addr == cmp_addr_reg[2] |=> match_out[3];
    endproperty
    a_opcode: assert property (p_opcode) else $error("opcode match missed");

    property p_dir;
        !range_on && cmp_ctl_reg[1][3:0] == 4'hd && data_write |-> !hit[1];
    endproperty
    a_dir: assert property (p_dir) else $error("write hit a read-only comparator");

    property p_dmask;
        cmp_ctl_reg[0][dcs_pkg::DCE_BIT] && !cmp_ctl_reg[0][dcs_pkg::OPC_BIT] &&
            (((data_bus ^ data_val_reg) & data_mask_reg) != 32'h00000000) |-> !hit[0];
    endproperty
    a_dmask: assert property (p_dmask) else $error("masked data mismatch matched");

    property p_force;
        armed && !disarm_wr && ext_event && ftgt_reg != dcs_pkg::TGT_FINAL
            |=> state_reg == dcs_pkg::dcs_state_t'($past(ftgt_reg));
    endproperty
    a_force: assert property (p_force) else $error("forced move went wrong");

    property p_match_move;
        armed && !wr_ctrl && !ext_event && hit[0] && cmp_ctl_reg[0][6:5] != 2'h0
            |=> state_reg == dcs_pkg::dcs_state_t'($past(cmp_ctl_reg[0][6:5]));
    endproperty
    a_match_move: assert property (p_match_move) else $error("match move went wrong");

    property p_fired;
        hit[1] && !arm_wr |=> fired_reg[1] ##1 (fired_reg[1] || $past(arm_wr));
    endproperty
    a_fired: assert property (p_fired) else $error("fired latch lost");

    property p_range;
        range_reg == dcs_pkg::RANGE_IN && cmp_ctl_reg[0][1:0] == 2'h1 && data_valid &&
            g_cmp[0].rw_ok && g_cmp[0].d_ok &&
            data_addr >= cmp_addr_reg[0] && data_addr <= cmp_addr_reg[1] |=> match_out[0] && !match_out[1];
    endproperty
    a_range: assert property (p_range) else $error("range match missed");

    property p_irq;
        bk_ev && mask_reg[0] && !wr_mask |=> irq ##1 (irq || $past(rd_status) || $past(wr_mask));
    endproperty
    a_irq: assert property (p_irq) else $error("breakpoint irq missing");

    property p_opc_free;
        cmp_ctl_reg[0][1:0] == 2'h3 && pc_exec_valid && pc_exec_addr == cmp_addr_reg[0] |-> hit[0];
    endproperty
    a_opc_free: assert property (p_opc_free) else $error("opcode match held off by qualifiers");

    c_state3: cover property (state_reg == dcs_pkg::DCS_S3);
    c_bkpt:   cover property (breakpoint);
    c_range:  cover property (range_on && hit[0]);
    c_read:   cover property (rd_pend_reg ##1 hreadyout);
    c_force:  cover property (force_go && !final_go);
endmodule // dcs_top

// [dcs_pkg.sv]
// Shared constants and types of the debug comparator sequencer
package dcs_pkg;
    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] CTRL1_OFF  = 8'h00;
    localparam logic [7:0] RANGE_OFF  = 8'h04;
    localparam logic [7:0] STATUS_OFF = 8'h08;
    localparam logic [7:0] MASK_OFF   = 8'h0c;
    localparam logic [7:0] SEQ_OFF    = 8'h10;
    localparam logic [3:0] CMP_BASE   = 4'h2;
    localparam logic [3:0] CMP_CTL    = 4'h0;
    localparam logic [3:0] CMP_ADDR   = 4'h4;
    localparam logic [3:0] CMP_DATA   = 4'h8;
    localparam logic [3:0] CMP_DMASK  = 4'hc;
    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int ARM_BIT   = 0;
    localparam int FORCE_BIT = 1;
    localparam int BKEN_BIT  = 2;
    localparam int FTGT_LSB  = 4;
    localparam int EN_BIT    = 0;
    localparam int OPC_BIT   = 1;
    localparam int ATCE_BIT  = 2;
    localparam int RDSEL_BIT = 3;
    localparam int DCE_BIT   = 4;
    localparam int TGT_LSB   = 5;
    localparam int FIRED_LSB = 4;
    // ************************************************************
    // Reset values and encodings
    // ************************************************************
    localparam logic [7:0]  CTL_RST   = 8'h00;
    localparam logic [23:0] ADDR_RST  = 24'h000000;
    localparam logic [31:0] DATA_RST  = 32'h00000000;
    localparam logic [31:0] DMASK_RST = 32'hffffffff;
    localparam logic [1:0]  TGT_FINAL = 2'h0;
    localparam logic [1:0]  RANGE_OFF_MODE = 2'h0;
    localparam logic [1:0]  RANGE_IN  = 2'h1;
    typedef enum logic [1:0] {DCS_IDLE, DCS_S1, DCS_S2, DCS_S3} dcs_state_t;
endpackage

// [dcs_core_model.sv]
// Behavioural model of the processor core buses watched by the comparators
`timescale 1ns/1ps
module dcs_core_model (
    input  wire logic hclk,
    output logic        pc_exec_valid,
    output logic [23:0] pc_exec_addr,
    output logic        data_valid,
    output logic        data_write,
    output logic [23:0] data_addr,
    output logic [31:0] data_bus,
    output logic        ext_event
);
    initial begin
        pc_exec_valid = 1'b0;
        pc_exec_addr  = 24'h000000;
        data_valid    = 1'b0;
        data_write    = 1'b0;
        data_addr     = 24'h000000;
        data_bus      = 32'h00000000;
        ext_event     = 1'b0;
    end
    // ************************************************************
    // Bus cycles
    // ************************************************************
    // Idle buses show the inverse value, so a stale address never matches
    task automatic fetch(input logic [23:0] a);
        @(posedge hclk);
        pc_exec_valid <= 1'b1;
        pc_exec_addr  <= a;
        @(posedge hclk);
        pc_exec_valid <= 1'b0;
        pc_exec_addr  <= ~a;
    endtask
    task automatic access(input logic w, input logic [23:0] a, input logic [31:0] d);
        @(posedge hclk);
        data_valid <= 1'b1;
        data_write <= w;
        data_addr  <= a;
        data_bus   <= d;
        @(posedge hclk);
        data_valid <= 1'b0;
        data_write <= ~w;
        data_addr  <= ~a;
        data_bus   <= ~d;
    endtask
    task automatic pulse_event();
        @(posedge hclk);
        ext_event <= 1'b1;
        @(posedge hclk);
        ext_event <= 1'b0;
    endtask
endmodule // dcs_core_model

// [dcs_top_test.sv]
// Self-checking testbench of the debug comparator sequencer
`timescale 1ns/1ps
module dcs_top_test;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, breakpoint, irq;
    logic [31:0] haddr, hwdata, hrdata, rd_q;
    logic [1:0]  htrans, seq_state;
    logic [3:0]  match_out;
    logic        pc_exec_valid, data_valid, data_write, ext_event;
    logic [23:0] pc_exec_addr, data_addr;
    logic [31:0] data_bus;
    int          err_count, checks;

    dcs_top i_dcs_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .pc_exec_valid(pc_exec_valid), .pc_exec_addr(pc_exec_addr),
        .data_valid(data_valid), .data_write(data_write), .data_addr(data_addr), .data_bus(data_bus),
        .ext_event(ext_event), .breakpoint(breakpoint), .match_out(match_out), .seq_state(seq_state),
        .irq(irq));
    dcs_core_model i_dcs_core_model (.hclk(hclk), .pc_exec_valid(pc_exec_valid),
        .pc_exec_addr(pc_exec_addr), .data_valid(data_valid), .data_write(data_write),
        .data_addr(data_addr), .data_bus(data_bus), .ext_event(ext_event));

    always #4 hclk = ~hclk;
    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic close_out();
        if (err_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Ready and read data are taken as they stand at the rising edge
    task automatic wait_rdy();
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd_q = hrdata;
    endtask
    task automatic addr_ph(input logic [7:0] a, input logic w);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h000000, a};
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hsel   <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr_ph(a, 1'b1);
        hwdata <= d;
        wait_rdy();
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        addr_ph(a, 1'b0);
        wait_rdy();
        chk(rd_q, exp);
    endtask
    task automatic outs(input int n, input logic i, input logic b, input logic [3:0] m, input logic [1:0] s);
        repeat (n) @(posedge hclk);
        #1;
        chk(32'({irq, breakpoint, match_out, seq_state}), 32'({i, b, m, s}));
    endtask
    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h00000000;
        err_count = 0;
        checks = 0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(8'h2c, 32'hffffffff);
        rdc(8'h80, 32'h00000000);
        chk(32'(hresp), 32'h00000000);
        // Opcode match on A, final target with breakpoint
        wr(8'h0c, 32'h00000001);
        wr(8'h24, 32'h00001234);
        wr(8'h20, 32'h00000003);
        wr(8'h00, 32'h00000005);
        i_dcs_core_model.fetch(24'h001234);
        outs(0, 1'b1, 1'b1, 4'h1, 2'h0);
        outs(1, 1'b1, 1'b0, 4'h0, 2'h0);
        rdc(8'h10, 32'h00000010);
        rdc(8'h08, 32'h00000003);
        outs(1, 1'b0, 1'b0, 4'h0, 2'h0);
        // Data mode on A: reads only, masked data compare, target 2
        wr(8'h24, 32'h00000300);
        wr(8'h28, 32'h00aa00bb);
        wr(8'h2c, 32'h00ff00ff);
        wr(8'h20, 32'h0000005d);
        wr(8'h00, 32'h00000001);
        i_dcs_core_model.access(1'b1, 24'h000300, 32'h00aa00bb);
        outs(0, 1'b0, 1'b0, 4'h0, 2'h1);
        i_dcs_core_model.access(1'b0, 24'h000300, 32'h11aa22bb);
        outs(0, 1'b0, 1'b0, 4'h1, 2'h2);
        i_dcs_core_model.access(1'b0, 24'h000300, 32'h00ab00bb);
        outs(0, 1'b0, 1'b0, 4'h0, 2'h2);
        i_dcs_core_model.fetch(24'h000300);
        outs(0, 1'b0, 1'b0, 4'h0, 2'h2);
        rdc(8'h08, 32'h00000002);
        wr(8'h00, 32'h00000000);
        i_dcs_core_model.access(1'b0, 24'h000300, 32'h00aa00bb);
        #1;
        chk(32'(seq_state), 32'h00000000);
        // B and D opcode matches, then forced moves
        wr(8'h34, 32'h00009999);
        wr(8'h30, 32'h00000023);
        wr(8'h44, 32'h00005678);
        wr(8'h40, 32'h00000063);
        wr(8'h00, 32'h00000001);
        i_dcs_core_model.fetch(24'h005678);
        outs(0, 1'b0, 1'b0, 4'h8, 2'h3);
        i_dcs_core_model.fetch(24'h009999);
        outs(0, 1'b0, 1'b0, 4'h2, 2'h1);
        wr(8'h00, 32'h00000021);
        wr(8'h00, 32'h00000023);
        outs(2, 1'b0, 1'b0, 4'h0, 2'h2);
        wr(8'h00, 32'h00000031);
        i_dcs_core_model.pulse_event();
        outs(0, 1'b0, 1'b0, 4'h0, 2'h3);
        // Inside range A..B replaces the exact match of A
        wr(8'h04, 32'h00000001);
        i_dcs_core_model.access(1'b0, 24'h000400, 32'h00aa00bb);
        outs(0, 1'b0, 1'b0, 4'h1, 2'h2);
        // Mid-run reset clears the sequencer and the registers
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        chk(32'(hreadyout), 32'h00000001);
        hresetn <= 1'b1;
        outs(0, 1'b0, 1'b0, 4'h0, 2'h0);
        rdc(8'h04, 32'h00000000);
        rdc(8'h10, 32'h00000000);
        // B in data mode, exact address, reads only, final target without breakpoint
        wr(8'h34, 32'h00000500);
        wr(8'h30, 32'h0000000d);
        wr(8'h00, 32'h00000001);
        i_dcs_core_model.access(1'b1, 24'h000500, 32'h00000000);
        outs(0, 1'b0, 1'b0, 4'h0, 2'h1);
        i_dcs_core_model.access(1'b0, 24'h000500, 32'h00000000);
        outs(0, 1'b0, 1'b0, 4'h2, 2'h0);
        wr(8'h30, 32'h00000001);
        i_dcs_core_model.access(1'b1, 24'h000500, 32'h00000000);
        outs(0, 1'b0, 1'b0, 4'h2, 2'h0);
        close_out();
    end
    // Whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge hclk);
        err_count++;
        close_out();
    end
endmodule // dcs_top_test
